// ### tb/quad_encoder.sv
// Quadrature encoder model that drives the two phase lines
`timescale 1ns/1ns
`default_nettype none
module quad_encoder #(
   parameter int HOLD = 8
) (
   input  wire logic       sys_clk,
   input  wire logic       run,
   input  wire logic [1:0] mode,
   output logic            phase_a,
   output logic            phase_b,
   output logic [31:0]     moves
);
   logic [1:0] pos = 2'h0;
   int         cnt = 0;
   logic [1:0] gray [4] = '{2'h0, 2'h1, 2'h3, 2'h2};

   // Encoder drives both lines at all times, as a real push-pull encoder does
   assign {phase_a, phase_b} = gray[pos];

   initial moves = 32'h0;

   // One move per HOLD cycles, so every position is seen by at least one sample tick
   always @(posedge sys_clk) begin
      if (run && cnt == HOLD - 1) begin
         cnt <= 0;
         moves <= moves + 32'h1;
         case (mode)
            2'h0: pos <= pos + 2'h1;
            2'h1: pos <= pos - 2'h1;
            default: pos <= pos + 2'h2; // Both lines flip at once
         endcase
      end else if (run) begin
         cnt <= cnt + 1;
      end else begin
         cnt <= 0;
      end
   end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the motion task and event block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   localparam int HOLD = 8;
   logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq, run, er;
   logic phase_a, phase_b;
   logic [1:0] mode;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, moves, exp_m, base, c, k;
   int n_fail, total_checks, cycles, i, j;

   motion_events motion_events_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .phase_a(phase_a),
      .phase_b(phase_b), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
   quad_encoder #(.HOLD(HOLD)) quad_encoder_i (.sys_clk(sys_clk), .run(run), .mode(mode),
      .phase_a(phase_a), .phase_b(phase_b), .moves(moves));

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // Hang guard, far above the fewer than a thousand cycles the tests need
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         stop_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; waits on pready rather than assuming zero wait states
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rdat, output logic err);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rd, er);
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, rd, er);
      chk(rd, exp);
   endtask

   // Runs the encoder for n moves, then lets the sampling pipeline settle
   task automatic move(input logic [1:0] m, input logic [31:0] n);
      mode <= m;
      run <= 1'b1;
      repeat (n * HOLD) @(posedge sys_clk);
      run <= 1'b0;
      repeat (16) @(posedge sys_clk);
   endtask

   initial begin
      {sys_rst, psel, penable, pwrite, run} = 5'h10;
      paddr = 12'h000;
      pwdata = 32'h0;
      mode = 2'h0;
      exp_m = 32'h0;
      void'($urandom(5942));
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      for (i = 0; i < 4; i++) rchk(12'h100 + 12'(4 * i), 32'h0);
      rchk(12'h508, 32'h31);
      rchk(12'h510, 32'h0000000A);
      apb(1'b0, 12'h7F0, 32'h0, rd, er);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      chk({31'h0, irq}, 32'h0);
      $display("Test reset values done");
      wr(12'h508, 32'h2);
      wr(12'h510, 32'h2);
      wr(12'h604, 32'h1);
      wr(12'h000, 32'h1);
      // First stretch fixed forward so a non-null report is certain
      move(2'h0, 32'h3);
      exp_m = 32'h3;
      for (i = 0; i < 3; i++) begin
         c = $urandom % 2;
         k = 1 + $urandom % 6;
         move(c[1:0], k);
         exp_m = (c == 32'h0) ? exp_m + k : exp_m - k;
      end
      rchk(12'h514, exp_m);
      rchk(12'h100, 32'h1);
      rchk(12'h104, 32'h1);
      chk({31'h0, irq}, 32'h1);
      $display("Test random motion done");
      wr(12'h00C, 32'h1);
      rchk(12'h518, exp_m);
      rchk(12'h514, 32'h0);
      wr(12'h104, 32'h0);
      repeat (40) @(posedge sys_clk);
      rchk(12'h104, 32'h0);
      $display("Test motion read-clear done");
      k = 1 + $urandom % 5;
      move(2'h2, k);
      rchk(12'h544, k);
      rchk(12'h514, 32'h0);
      rchk(12'h10C, 32'h1);
      rchk(12'h108, 32'h0);
      rchk(12'h104, 32'h0);
      wr(12'h010, 32'h1);
      rchk(12'h548, k);
      rchk(12'h544, 32'h0);
      wr(12'h10C, 32'h0);
      repeat (40) @(posedge sys_clk);
      rchk(12'h10C, 32'h0);
      $display("Test double transitions done");
      // Read-clears swept across the step phase, both directions
      for (i = 0; i < 2; i++) begin
         wr(12'h00C, 32'h1);
         base = moves;
         k = 32'h0;
         mode <= 2'(i);
         run <= 1'b1;
         for (j = 0; j < 8; j++) begin
            repeat (5 + j) @(posedge sys_clk);
            wr(12'h00C, 32'h1);
            apb(1'b0, 12'h518, 32'h0, c, er);
            k = k + c;
         end
         run <= 1'b0;
         repeat (16) @(posedge sys_clk);
         apb(1'b0, 12'h514, 32'h0, rd, er);
         chk(k + rd, (i == 0) ? moves - base : base - moves);
      end
      $display("Test atomic read-clear done");
      wr(12'h004, 32'h1);
      repeat (16) @(posedge sys_clk);
      rchk(12'h50C, 32'h0);
      rchk(12'h100, 32'h1);
      wr(12'h100, 32'h0);
      rchk(12'h100, 32'h0);
      apb(1'b0, 12'h600, 32'h0, rd, er);
      chk({31'h0, rd[0]}, 32'h1);
      rchk(12'h600, 32'h0);
      chk({31'h0, irq}, 32'h0);
      $display("Test flags and interrupt done");
      stop_test();
   end
endmodule
`default_nettype wire

// ### verilog/motion_defines.svh
// Offsets, field positions, reset values and widths of the motion task and event block
`ifndef MOTION_DEFINES_SVH
`define MOTION_DEFINES_SVH

// Register byte offsets
`define START_TASK_OFS                  12'h000
`define STOP_TASK_OFS                   12'h004
`define MOTION_TOTAL_READCLEAR_TASK_OFS 12'h00C
`define TWO_STEP_READCLEAR_TASK_OFS     12'h010
`define EVENT_BASE_OFS                  12'h100
`define NEW_SAMPLE_EVENT_FLAG_OFS       12'h100
`define REPORT_EVENT_FLAG_OFS           12'h104
`define TOTAL_OVERFLOW_EVENT_FLAG_OFS   12'h108
`define TWO_STEP_EVENT_FLAG_OFS         12'h10C
`define SAMPLE_INTERVAL_OFS             12'h508
`define SAMPLE_VALUE_OFS                12'h50C
`define REPORT_INTERVAL_OFS             12'h510
`define MOTION_TOTAL_OFS                12'h514
`define MOTION_TOTAL_COPY_OFS           12'h518
`define TWO_STEP_TOTAL_OFS              12'h544
`define TWO_STEP_COPY_OFS               12'h548
`define INT_STATUS_OFS                  12'h600
`define INT_MASK_OFS                    12'h604

// Field positions
`define TASK_TRIGGER_BIT 0
`define EVENT_FLAG_BIT   0
`define EV_NEW_SAMPLE    0
`define EV_REPORT        1
`define EV_OVERFLOW      2
`define EV_TWO_STEP      3
`define EV_COUNT         4

// Widths and limits
`define TOTAL_W    32
`define INTERVAL_W 16
`define TOTAL_MAX  32'h7FFFFFFF
`define TOTAL_MIN  32'h80000000
`define COUNT_MAX  32'hFFFFFFFF

// Reset values
`define SAMPLE_INTERVAL_RESET 16'h0031
`define REPORT_INTERVAL_RESET 16'h000A
`define REG_RESET             32'h00000000

`endif

// ### verilog/motion_events.sv
// Function
// (RULE_01) Motion read-clear task: copy total, then zero
// (RULE_02) Two-step read-clear task: copy total, then zero
// (RULE_03) Read-clear is atomic; no step lost
// (RULE_04) New-sample flag on every sample update
// (RULE_05) Report flag after interval if motion nonzero
// (RULE_06) Overflow flag when either total overflows
// (RULE_07) Two-step flag after interval if nonzero
// (RULE_08) Totals count steps and double transitions
// (RULE_09) Report interval sets samples per report
// (RULE_10) After start, sample updates every interval
// (RULE_11) Flags stay set until written zero
`timescale 1ns/1ns
`default_nettype none
`include "motion_defines.svh"
module motion_events (
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic        phase_a,
   input  wire logic        phase_b,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq
);
   motion_pkg::core_state_type st_r;
   motion_pkg::core_state_type st_nxt;
   motion_link_if               link ();

   // Bus decode and task triggers
   logic [11:0]          addr_al;
   logic                 bus_wr;
   logic                 bus_rd;
   logic                 rc_motion;
   logic                 rc_two_step;

   // Per-sample steps and overflow
   logic                 up;
   logic                 down;
   logic                 dbl_inc;
   logic                 motion_ovf;
   logic                 two_step_ovf;
   logic [`TOTAL_W-1:0]  delta;

   // Event set and clear vectors
   logic [`EV_COUNT-1:0] ev_set;
   logic [`EV_COUNT-1:0] ev_clr;

   // Offsets that answer without error
   function automatic logic addr_known(input logic [11:0] a);
      case (a)
         `START_TASK_OFS, `STOP_TASK_OFS, `MOTION_TOTAL_READCLEAR_TASK_OFS,
         `TWO_STEP_READCLEAR_TASK_OFS, `NEW_SAMPLE_EVENT_FLAG_OFS, `REPORT_EVENT_FLAG_OFS,
         `TOTAL_OVERFLOW_EVENT_FLAG_OFS, `TWO_STEP_EVENT_FLAG_OFS, `SAMPLE_INTERVAL_OFS,
         `SAMPLE_VALUE_OFS, `REPORT_INTERVAL_OFS, `MOTION_TOTAL_OFS, `MOTION_TOTAL_COPY_OFS,
         `TWO_STEP_TOTAL_OFS, `TWO_STEP_COPY_OFS, `INT_STATUS_OFS, `INT_MASK_OFS:
            addr_known = 1'b1;
         default:
            addr_known = 1'b0;
      endcase
   endfunction

   // Read data by offset; task registers read as zero
   function automatic logic [31:0] read_mux(input logic [11:0] a,
                                            input motion_pkg::core_state_type s);
      case (a)
         `NEW_SAMPLE_EVENT_FLAG_OFS:     read_mux = {31'h00000000, s.ev[`EV_NEW_SAMPLE]};
         `REPORT_EVENT_FLAG_OFS:         read_mux = {31'h00000000, s.ev[`EV_REPORT]};
         `TOTAL_OVERFLOW_EVENT_FLAG_OFS: read_mux = {31'h00000000, s.ev[`EV_OVERFLOW]};
         `TWO_STEP_EVENT_FLAG_OFS:       read_mux = {31'h00000000, s.ev[`EV_TWO_STEP]};
         `SAMPLE_INTERVAL_OFS:           read_mux = {16'h0000, s.sample_interval};
         `SAMPLE_VALUE_OFS:              read_mux = s.sample_value;
         `REPORT_INTERVAL_OFS:           read_mux = {16'h0000, s.report_interval};
         `MOTION_TOTAL_OFS:              read_mux = s.motion_total;
         `MOTION_TOTAL_COPY_OFS:         read_mux = s.motion_total_copy;
         `TWO_STEP_TOTAL_OFS:            read_mux = s.two_step_total;
         `TWO_STEP_COPY_OFS:             read_mux = s.two_step_copy;
         `INT_STATUS_OFS:                read_mux = {28'h0000000, s.int_status};
         `INT_MASK_OFS:                  read_mux = {28'h0000000, s.int_mask};
         default:                        read_mux = 32'h00000000;
      endcase
   endfunction

   sample_timer u_timer (
      .sys_clk         (sys_clk),
      .sys_rst         (sys_rst),
      .running         (st_r.running),
      .sample_interval (st_r.sample_interval),
      .report_interval (st_r.report_interval),
      .link            (link.timer_mp)
   );

   phase_decoder u_decoder (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .phase_a (phase_a),
      .phase_b (phase_b),
      .link    (link.decoder_mp)
   );

   // Bus qualifiers and per-sample step decode
   always_comb begin
      addr_al = {paddr[11:2], 2'h0};
      bus_wr = psel && penable && pwrite;
      bus_rd = psel && penable && !pwrite;
      // A task fires only with its trigger bit set
      rc_motion = bus_wr && addr_al == `MOTION_TOTAL_READCLEAR_TASK_OFS &&
                  pwdata[`TASK_TRIGGER_BIT];
      rc_two_step = bus_wr && addr_al == `TWO_STEP_READCLEAR_TASK_OFS &&
                    pwdata[`TASK_TRIGGER_BIT];
      // Steps count only on the sample strobe
      up = link.sample_done && link.step_up;
      down = link.sample_done && link.step_down;
      dbl_inc = link.sample_done && link.dbl;
      delta = up ? 32'h00000001 : (down ? 32'hFFFFFFFF : 32'h00000000);
      // A freshly cleared total cannot overflow on one step
      motion_ovf = !rc_motion && ((up && st_r.motion_total == `TOTAL_MAX) ||
                                  (down && st_r.motion_total == `TOTAL_MIN)); // [RULE_06]
      two_step_ovf = !rc_two_step && dbl_inc && st_r.two_step_total == `COUNT_MAX;
   end

   // Next state of registers, totals and flags
   always_comb begin
      st_nxt = st_r;
      ev_set = '0;
      ev_clr = '0;
      // Read data captured in setup so prdata comes from a flop
      if (psel && !penable && !pwrite) begin
         st_nxt.prdata = read_mux(addr_al, st_r);
      end
      if (bus_wr && addr_al == `START_TASK_OFS && pwdata[`TASK_TRIGGER_BIT]) begin
         st_nxt.running = 1'b1;
      end
      // Stop is decoded last, so it wins a clash
      if (bus_wr && addr_al == `STOP_TASK_OFS && pwdata[`TASK_TRIGGER_BIT]) begin
         st_nxt.running = 1'b0;
      end
      if (bus_wr && addr_al == `SAMPLE_INTERVAL_OFS) begin
         st_nxt.sample_interval = pwdata[`INTERVAL_W-1:0];
      end
      if (bus_wr && addr_al == `REPORT_INTERVAL_OFS) begin
         st_nxt.report_interval = pwdata[`INTERVAL_W-1:0];
      end
      if (bus_wr && addr_al == `INT_MASK_OFS) begin
         st_nxt.int_mask = pwdata[`EV_COUNT-1:0];
      end
      // Copy and restart from this cycle's step, so nothing counted is lost
      if (rc_motion) begin
         st_nxt.motion_total_copy = st_r.motion_total; // [RULE_01]
         st_nxt.motion_total = delta; // [RULE_03]
      end else if (!motion_ovf) begin
         st_nxt.motion_total = st_r.motion_total + delta; // [RULE_08]
      end
      if (rc_two_step) begin
         st_nxt.two_step_copy = st_r.two_step_total; // [RULE_02]
         st_nxt.two_step_total = {31'h00000000, dbl_inc}; // [RULE_03]
      end else if (dbl_inc && !two_step_ovf) begin
         st_nxt.two_step_total = st_r.two_step_total + 32'h00000001; // [RULE_08]
      end
      if (link.sample_done) begin
         st_nxt.sample_value = delta;
      end
      ev_set[`EV_NEW_SAMPLE] = link.sample_done; // [RULE_04]
      ev_set[`EV_REPORT] = link.report_done && st_nxt.motion_total != '0; // [RULE_05]
      ev_set[`EV_OVERFLOW] = motion_ovf || two_step_ovf; // [RULE_06]
      ev_set[`EV_TWO_STEP] = link.report_done && st_nxt.two_step_total != '0; // [RULE_07]
      // Written zero clears a flag; a set in the same cycle still wins
      for (int i = 0; i < `EV_COUNT; i++) begin
         ev_clr[i] = bus_wr && !pwdata[`EVENT_FLAG_BIT] &&
                     addr_al == (`EVENT_BASE_OFS + 12'(4 * i));
         st_nxt.ev[i] = ev_set[i] || (st_r.ev[i] && !ev_clr[i]); // [RULE_11]
      end
      // Read clears only the bits that the read returned
      st_nxt.int_status = ev_set | (st_r.int_status &
         ~((bus_rd && addr_al == `INT_STATUS_OFS) ? st_r.prdata[`EV_COUNT-1:0] : 4'h0));
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_r <= '0;
         // Intervals come up at their defaults
         st_r.sample_interval <= `SAMPLE_INTERVAL_RESET;
         st_r.report_interval <= `REPORT_INTERVAL_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Zero-wait slave; error only on unmapped offsets
   assign prdata = st_r.prdata;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_known(addr_al);
   // Level interrupt while a masked status bit is set
   assign irq = |(st_r.int_status & st_r.int_mask);

   // Task, count and flag checks
   a_motion_copy: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_01]
      rc_motion |=> st_r.motion_total_copy == $past(st_r.motion_total))
      else $error("motion snapshot wrong");
   a_motion_zero: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_01]
      (rc_motion && !link.sample_done) |=> st_r.motion_total == 32'h00000000)
      else $error("motion total not cleared");
   a_two_step_copy: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_02]
      rc_two_step |=> st_r.two_step_copy == $past(st_r.two_step_total) &&
                      st_r.two_step_total == {31'h00000000, $past(dbl_inc)})
      else $error("two-step snapshot or clear wrong");
   a_atomic_keep: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_03]
      (rc_motion && (up || down)) |=> st_r.motion_total == $past(delta))
      else $error("step lost during read-clear");
   a_sample_flag: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_04]
      link.sample_done |=> st_r.ev[`EV_NEW_SAMPLE] && st_r.int_status[`EV_NEW_SAMPLE])
      else $error("new-sample flag not set");
   a_report_flag: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_05]
      (link.report_done && !st_r.ev[`EV_REPORT]) |=>
         st_r.ev[`EV_REPORT] == (st_r.motion_total != 32'h00000000))
      else $error("report flag disagrees with motion total");
   a_overflow_hold: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_06]
      motion_ovf |=> st_r.ev[`EV_OVERFLOW] && $stable(st_r.motion_total))
      else $error("overflow not flagged or total moved");
   a_two_step_flag: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_07]
      (link.report_done && !st_r.ev[`EV_TWO_STEP]) |=>
         st_r.ev[`EV_TWO_STEP] == (st_r.two_step_total != 32'h00000000))
      else $error("two-step flag disagrees with total");
   a_step_count: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_08]
      (up && !rc_motion && !motion_ovf) |=> st_r.motion_total == $past(st_r.motion_total) + 1)
      else $error("step not accumulated");
   a_flag_sticky: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_11]
      (st_r.ev[`EV_REPORT] && !ev_clr[`EV_REPORT]) |=> st_r.ev[`EV_REPORT])
      else $error("report flag dropped without a clear");

   // Two-step total restarts at zero on its task
   a_two_step_zero: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_02]
      (rc_two_step && !dbl_inc) |=>
         st_r.two_step_total == 32'h00000000)
      else $error("two-step total not cleared");

   // Motion snapshot moves only on its own task
   a_copy_hold: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_01]
      !rc_motion |=>
         $stable(st_r.motion_total_copy))
      else $error("motion snapshot moved without a task");

   // Two-step snapshot moves only on its own task
   a_two_copy_hold: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_02]
      !rc_two_step |=>
         $stable(st_r.two_step_copy))
      else $error("two-step snapshot moved without a task");

   // Reverse step takes one off the total
   a_down_count: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_08]
      (down && !rc_motion && !motion_ovf) |=>
         st_r.motion_total == $past(st_r.motion_total) - 32'h00000001)
      else $error("reverse step not accumulated");

   // Each double adds one to its own total
   a_two_step_count: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_08]
      (dbl_inc && !rc_two_step && !two_step_ovf) |=>
         st_r.two_step_total == $past(st_r.two_step_total) + 32'h00000001)
      else $error("double transition not accumulated");

   // A double leaves the motion total alone
   a_double_no_motion: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_08]
      (dbl_inc && !rc_motion) |=>
         $stable(st_r.motion_total))
      else $error("double transition moved the motion total");

   // Sample register takes each sample's step
   a_sample_value: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_04]
      link.sample_done |=>
         st_r.sample_value == $past(delta))
      else $error("sample value not updated");

   // Written zero clears when no sample lands
   a_sample_clear: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_11]
      (ev_clr[`EV_NEW_SAMPLE] && !link.sample_done) |=>
         !st_r.ev[`EV_NEW_SAMPLE])
      else $error("new-sample flag not cleared");

   // Overflow flag rises only on an overflow
   a_overflow_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_06]
      (!motion_ovf && !two_step_ovf && !st_r.ev[`EV_OVERFLOW]) |=>
         !st_r.ev[`EV_OVERFLOW])
      else $error("overflow flag without an overflow");

   // Report flag rises only at a report boundary
   a_report_idle: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_05]
      (!link.report_done && !st_r.ev[`EV_REPORT]) |=>
         !st_r.ev[`EV_REPORT])
      else $error("report flag outside a report");

   // Two-step flag likewise waits for a report
   a_two_step_idle: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_07]
      (!link.report_done && !st_r.ev[`EV_TWO_STEP]) |=>
         !st_r.ev[`EV_TWO_STEP])
      else $error("two-step flag outside a report");
endmodule
`default_nettype wire

// ### verilog/motion_link_if.sv
// Sample timing and decoded steps passed between the block's own modules
`timescale 1ns/1ns
`default_nettype none
interface motion_link_if;
   logic tick;
   logic report_tick;
   logic sample_done;
   logic report_done;
   logic step_up;
   logic step_down;
   logic dbl;

   modport timer_mp (output tick, output report_tick);
   modport decoder_mp (input tick, input report_tick, output sample_done, output report_done,
                       output step_up, output step_down, output dbl);
   modport core_mp (input sample_done, input report_done, input step_up, input step_down,
                    input dbl);
endinterface
`default_nettype wire

// ### verilog/motion_pkg.sv
// State types of the motion task and event block
package motion_pkg;
`include "motion_defines.svh"

   typedef struct packed {
      logic [1:0] sync1;
      logic [1:0] sync2;
      logic [1:0] last_ab;
      logic       sample_done;
      logic       report_done;
      logic       step_up;
      logic       step_down;
      logic       dbl;
   } decoder_state_type;

   typedef struct packed {
      logic [`INTERVAL_W-1:0] cnt;
      logic [`INTERVAL_W-1:0] rcnt;
      logic                   tick;
      logic                   report_tick;
   } timer_state_type;

   typedef struct packed {
      logic                   running;
      logic [`TOTAL_W-1:0]    motion_total;
      logic [`TOTAL_W-1:0]    motion_total_copy;
      logic [`TOTAL_W-1:0]    two_step_total;
      logic [`TOTAL_W-1:0]    two_step_copy;
      logic [`TOTAL_W-1:0]    sample_value;
      logic [`INTERVAL_W-1:0] sample_interval;
      logic [`INTERVAL_W-1:0] report_interval;
      logic [`EV_COUNT-1:0]   ev;
      logic [`EV_COUNT-1:0]   int_status;
      logic [`EV_COUNT-1:0]   int_mask;
      logic [31:0]            prdata;
   } core_state_type;
endpackage

// ### verilog/phase_decoder.sv
// Phase input synchroniser and per-sample transition decoder
`timescale 1ns/1ns
`default_nettype none
module phase_decoder (
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic       phase_a,
   input  wire logic       phase_b,
   motion_link_if.decoder_mp link
);
   motion_pkg::decoder_state_type st_r;
   motion_pkg::decoder_state_type st_nxt;

   // Forward order is 00, 01, 11, 10
   function automatic logic is_forward(input logic [1:0] prev, input logic [1:0] cur);
      is_forward = ({prev, cur} == 4'h1) || ({prev, cur} == 4'h7) ||
                   ({prev, cur} == 4'hE) || ({prev, cur} == 4'h8);
   endfunction

   // Compare against the last sampled phase pair at each tick
   always_comb begin
      st_nxt = st_r;
      st_nxt.sync1 = {phase_a, phase_b};
      st_nxt.sync2 = st_r.sync1;
      st_nxt.sample_done = link.tick;
      st_nxt.report_done = link.report_tick;
      st_nxt.step_up = 1'b0;
      st_nxt.step_down = 1'b0;
      st_nxt.dbl = 1'b0;
      if (link.tick) begin
         st_nxt.last_ab = st_r.sync2;
         // Both phases moved: direction is lost, only the double is counted
         if ((st_r.sync2 ^ st_r.last_ab) == 2'h3) begin // [RULE_08]
            st_nxt.dbl = 1'b1;
         end else if (st_r.sync2 != st_r.last_ab) begin
            st_nxt.step_up = is_forward(st_r.last_ab, st_r.sync2);
            st_nxt.step_down = !is_forward(st_r.last_ab, st_r.sync2);
         end
      end
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign link.sample_done = st_r.sample_done;
   assign link.report_done = st_r.report_done;
   assign link.step_up = st_r.step_up;
   assign link.step_down = st_r.step_down;
   assign link.dbl = st_r.dbl;

   a_double_detect: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_08]
      (link.tick && (st_r.sync2 ^ st_r.last_ab) == 2'h3) |=> st_r.dbl && !st_r.step_up)
      else $error("double transition not flagged");
endmodule
`default_nettype wire

// ### verilog/sample_timer.sv
// Sample period and report interval counter
`timescale 1ns/1ns
`default_nettype none
`include "motion_defines.svh"
module sample_timer (
   input  wire logic                   sys_clk,
   input  wire logic                   sys_rst,
   input  wire logic                   running,
   input  wire logic [`INTERVAL_W-1:0] sample_interval,
   input  wire logic [`INTERVAL_W-1:0] report_interval,
   motion_link_if.timer_mp             link
);
   motion_pkg::timer_state_type st_r;
   motion_pkg::timer_state_type st_nxt;

   // One tick every sample_interval+1 cycles; a report every report_interval ticks
   always_comb begin
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      st_nxt.report_tick = 1'b0;
      if (!running) begin
         st_nxt.cnt = '0;
         st_nxt.rcnt = '0;
      end else if (st_r.cnt >= sample_interval) begin // [RULE_10]
         st_nxt.cnt = '0;
         st_nxt.tick = 1'b1;
         // Zero interval behaves as one, so a report is never starved
         if ((st_r.rcnt + 16'h0001) >= report_interval) begin // [RULE_09]
            st_nxt.rcnt = '0;
            st_nxt.report_tick = 1'b1;
         end else begin
            st_nxt.rcnt = st_r.rcnt + 16'h0001;
         end
      end else begin
         st_nxt.cnt = st_r.cnt + 16'h0001;
      end
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign link.tick = st_r.tick;
   assign link.report_tick = st_r.report_tick;

   a_report_on_tick: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_09]
      st_r.report_tick |-> st_r.tick)
      else $error("report tick without sample tick");
   a_tick_spacing: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE_10]
      (st_r.tick && running && $stable(sample_interval) && sample_interval == 16'h0002)
      |=> !st_r.tick ##1 !st_r.tick)
      else $error("sample ticks closer than the interval");
endmodule
`default_nettype wire
